// file: design/ass_cfg.svh
// constants of the adc scan sequencer
// Functional notes
// - csr bit 14 clear stores offset binary, set stores two's complement
// - bit 15 is sample msb; offset binary zero is 8000, full scale ffff
// - two's complement zero is 0000, +full 7fff, -full 8000
// - block is 1, 8, 16, 32 or 64 channels from ccr bits 5..0
// - buffer starts at 0080, size 16..1024 words from ccr bits 15..11
// - first block at lowest buffer address, later blocks ascending
// - 2048 words of memory; 0880..0ffe and unused buffer are scratch
// - one scan per programmed sample rate, 100 khz when unprogrammed
// - fixed gain x1 or x10, or per-channel gain from gain memory
// - auto scan after reset or with both mode bits clear
// - ccr 5800 gives auto scan, 64 buffer, 64 block, gain x1
// - single scan fills the buffer once, cycling through the block, waits for next trigger
// - ccr 5840 gives single scan, 64 buffer, 64 block, gain x1
// - any write to 000e starts the scan when software trigger enabled
// - csr 8000/9000/a000 also led off, offset binary, 16-bit timer
// - csr 9000 enables external trigger on falling start edge
// - csr a000: one scan each time the interval timer expires
// - random access converts ccr channel 5..0, result at 0080
// - ccr 5880 gives random access channel 0, gain x1
// - random access, software trigger: write to 000e converts once
// - random access converts on timer expiry or falling start edge
// - host read of buffer word 0080 clears data ready csr bit 6
// - any write to 000c resets to auto scan at 100 khz
`ifndef ASS_CFG_SVH
`define ASS_CFG_SVH
// board offsets (byte addresses, 16-bit words in low bits of apb data)
`define ASS_CSR_OFF      16'h0002
`define ASS_CCR_OFF      16'h0004
`define ASS_RATE_OFF     16'h0006
`define ASS_RESET_OFF    16'h000C
`define ASS_TRIG_OFF     16'h000E
`define ASS_GAIN_OFF     16'h0010
`define ASS_TIMER_OFF    16'h0020
`define ASS_BUF_OFF      16'h0080
`define ASS_MEM_END      16'h0FFE
// csr fields
`define ASS_CSR_SWTRIG   15
`define ASS_CSR_TWOS     14
`define ASS_CSR_TIMER    13
`define ASS_CSR_EXTTRIG  12
`define ASS_CSR_LED      8
`define ASS_CSR_READY    6
// ccr fields
`define ASS_CCR_BUF_LSB  11
`define ASS_CCR_MODE_LSB 6
`define ASS_CCR_AGAIN    9
`define ASS_CCR_GAIN10   10
// reset values
`define ASS_CCR_RESET    16'h5800
`define ASS_CSR_RESET    16'h8000
`define ASS_RATE_RESET   16'h0000
`define ASS_TIMER_RESET  16'h0000
// timing
`define ASS_CLK_HZ       125000000
`define ASS_DEF_RATE_HZ  100000
`define ASS_TIMER_TICK_NS 160
`define ASS_CLK_NS       8
`endif

// file: design/ass_pkg.sv
// types of the adc scan sequencer
package ass_pkg;
    typedef enum logic [1:0] {
        ASS_MODE_AUTO,
        ASS_MODE_SINGLE,
        ASS_MODE_RANDOM,
        ASS_MODE_RSVD
    } ass_mode_t;
    typedef enum logic [1:0] {
        ASS_ST_IDLE,
        ASS_ST_CONV,
        ASS_ST_WAIT
    } ass_state_t;
endpackage

// file: design/ass_ram.sv
// dual-port word memory for data buffer, scratch and gain codes
module ass_ram #(
    parameter int DEPTH = 2048,
    parameter int AW    = 11
) (
    input  wire logic          clk,
    input  wire logic          a_we,
    input  wire logic [AW-1:0] a_addr,
    input  wire logic [15:0]   a_wdata,
    output logic      [15:0]   a_rdata,
    input  wire logic          b_we,
    input  wire logic [AW-1:0] b_addr,
    input  wire logic [15:0]   b_wdata
);
    logic [15:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
    end
endmodule

// file: design/ass_tick.sv
// programmable period tick generator for sample rate and interval timer
module ass_tick #(
    parameter int W = 24
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         restart,
    input  wire logic [W-1:0] period,
    output logic              tick
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (restart || cnt_q >= period) begin
            cnt_q <= '0;
            tick  <= !restart;
        end else begin
            cnt_q <= cnt_q + W'(1);
            tick  <= 1'b0;
        end
    end
endmodule

// file: design/ass_adc_scan_sequencer.sv
// scan sequencer with apb register slave and buffer formatting
`include "ass_cfg.svh"
module ass_adc_scan_sequencer import ass_pkg::*; #(
    parameter int CHANNELS    = 64,
    parameter int MEM_WORDS   = 2048,
    parameter int DEF_DIV     = `ASS_CLK_HZ / `ASS_DEF_RATE_HZ,
    parameter int TIMER_DIV   = `ASS_TIMER_TICK_NS / `ASS_CLK_NS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_start_n,
    input  wire logic        adc_done,
    input  wire logic [15:0] adc_data,
    output logic             adc_start,
    output logic [5:0]       adc_channel,
    output logic             adc_gain10,
    output logic             trigger_output_n,
    output logic             led_on
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] control_status_register;
        logic [15:0] channel_config_register;
        logic [15:0] rate;
        logic [15:0] timer;
        logic [5:0]  gain_ptr;
        logic [63:0] gains;
        ass_state_t  st;
        logic [10:0] idx;
        logic        ext_q;
        logic        rd_wait;
        logic        rd_buf0;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        adc_start;
        logic [5:0]  adc_channel;
        logic        adc_gain10;
        logic        trig_n;
        logic        led_on;
        logic        restart;
    } ass_state_s_t;

    ass_state_s_t s_q, s_d;

    logic [15:0] ram_rdata;
    logic        ram_a_we;
    logic [10:0] ram_a_addr;
    logic        ram_b_we;
    logic [10:0] ram_b_addr;
    logic [15:0] ram_b_wdata;
    logic        rate_tick;
    logic        timer_tick;
    logic [23:0] rate_period;
    logic [31:0] timer_period;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // buffer size decode
    // buffer size in words from ccr bits 15..11
    function automatic logic [10:0] buf_words(input logic [4:0] code);
        logic [10:0] w;
        w = 11'd64;
        case (code)
            5'b00000: w = 11'd16;
            5'b00001: w = 11'd32;
            5'b01011: w = 11'd64;
            5'b00011: w = 11'd128;
            5'b00111: w = 11'd256;
            5'b01111: w = 11'd512;
            5'b11111: w = 11'd1024;
            default:  w = 11'd64;
        endcase
        return w;
    endfunction

    // block size from ccr bits 5..0
    function automatic logic [6:0] blk_chans(input logic [5:0] code);
        logic [6:0] n;
        n = 7'd64;
        case (code[5:3])
            3'b000:  n = 7'd64;
            3'b001:  n = 7'd32;
            3'b010:  n = 7'd16;
            3'b011:  n = 7'd8;
            default: n = 7'd1;
        endcase
        return n;
    endfunction

    function automatic ass_mode_t mode_of(input logic [15:0] channel_config_register);
        return ass_mode_t'(channel_config_register[`ASS_CCR_MODE_LSB+1:`ASS_CCR_MODE_LSB] == 2'b01 ? 2'd1 :
                           channel_config_register[`ASS_CCR_MODE_LSB+1:`ASS_CCR_MODE_LSB] == 2'b10 ? 2'd2 :
                           channel_config_register[`ASS_CCR_MODE_LSB+1:`ASS_CCR_MODE_LSB] == 2'b00 ? 2'd0 : 2'd3);
    endfunction

    // ------------------------------------------------------------
    // tick sources
    // ------------------------------------------------------------
    // rate default
    assign rate_period = (s_q.rate == 16'h0000) ? 24'(DEF_DIV - 1)
                                                 : 24'({s_q.rate, 6'd0} - 22'd1);
    assign timer_period = {s_q.timer, 16'h0000} | 32'(TIMER_DIV * (s_q.timer + 16'd1) - 1);

    ass_tick #(.W(24)) u_rate (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (s_q.restart),
        .period  (rate_period),
        .tick    (rate_tick)
    );

    ass_tick #(.W(32)) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (s_q.restart),
        .period  (timer_period),
        .tick    (timer_tick)
    );

    // ------------------------------------------------------------
    // memory
    // ------------------------------------------------------------
    ass_ram #(.DEPTH(MEM_WORDS), .AW(11)) u_ram (
        .clk     (pclk),
        .a_we    (ram_a_we),
        .a_addr  (ram_a_addr),
        .a_wdata (pwdata[15:0]),
        .a_rdata (ram_rdata),
        .b_we    (ram_b_we),
        .b_addr  (ram_b_addr),
        .b_wdata (ram_b_wdata)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic        acc;
    logic        setup;
    logic        in_mem;
    logic        trig;
    logic        sw_trig;
    logic        ext_fall;
    ass_mode_t   mode;
    logic [10:0] words;
    logic [6:0]  chans;
    logic [5:0]  base_ch;
    logic [10:0] last_idx;
    logic [5:0]  ch;

    always_comb begin
        s_d         = s_q;
        ch          = 6'd0;
        setup       = psel && !penable;
        acc         = psel && penable;
        in_mem      = paddr >= `ASS_BUF_OFF && paddr <= `ASS_MEM_END;
        mode        = mode_of(s_q.channel_config_register);
        words       = buf_words(s_q.channel_config_register[15:11]);
        chans       = blk_chans(s_q.channel_config_register[5:0]);
        base_ch     = s_q.channel_config_register[5:0] & ~6'(chans - 7'd1);
        last_idx    = (mode == ASS_MODE_RANDOM) ? 11'd0 : words - 11'd1;
        ram_a_we    = 1'b0;
        ram_a_addr  = 11'((paddr - `ASS_BUF_OFF) >> 1);
        ram_b_we    = 1'b0;
        ram_b_addr  = 11'd0;
        ram_b_wdata = 16'h0000;
        s_d.restart = 1'b0;
        s_d.adc_start = 1'b0;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.ext_q   = external_start_n;
        ext_fall    = s_q.ext_q && !external_start_n && s_q.control_status_register[`ASS_CSR_EXTTRIG];
        sw_trig     = 1'b0;

        // apb slave: one wait state, ram read via rd_wait
        if (setup) begin
            s_d.rd_wait = 1'b1;
        end
        if (acc && s_q.rd_wait) begin
            s_d.rd_wait = 1'b0;
            s_d.pready  = 1'b1;
            s_d.prdata  = 32'h0;
            if (pwrite) begin
                case (paddr)
                    // csr codes set led, coding, timer mode
                    `ASS_CSR_OFF: begin
                        s_d.control_status_register = {pwdata[15:7], s_q.control_status_register[6], pwdata[5:0]};
                    end
                    `ASS_CCR_OFF: begin
                        s_d.channel_config_register = pwdata[15:0];
                        s_d.gain_ptr = 6'd0;
                        s_d.restart = 1'b1;
                        s_d.st = ASS_ST_IDLE;
                        s_d.idx = 11'd0;
                    end
                    `ASS_RATE_OFF:  s_d.rate = pwdata[15:0];
                    `ASS_TIMER_OFF: s_d.timer = pwdata[15:0];
                    `ASS_RESET_OFF: begin
                        s_d.channel_config_register  = `ASS_CCR_RESET;
                        s_d.control_status_register  = `ASS_CSR_RESET;
                        s_d.rate = `ASS_RATE_RESET;
                        s_d.st   = ASS_ST_IDLE;
                        s_d.idx  = 11'd0;
                        s_d.restart = 1'b1;
                    end
                    `ASS_TRIG_OFF: sw_trig = s_q.control_status_register[`ASS_CSR_SWTRIG];
                    `ASS_GAIN_OFF: begin
                        ram_b_we    = 1'b1;
                        ram_b_addr  = 11'(MEM_WORDS - CHANNELS) + 11'(s_q.gain_ptr);
                        ram_b_wdata = pwdata[15:0];
                        s_d.gains[s_q.gain_ptr] = pwdata[0];
                        s_d.gain_ptr = s_q.gain_ptr + 6'd1;
                    end
                    default: begin
                        ram_a_we    = in_mem;
                        s_d.pslverr = !in_mem;
                    end
                endcase
            end else begin
                case (paddr)
                    `ASS_CSR_OFF:  s_d.prdata = {16'h0, s_q.control_status_register};
                    `ASS_CCR_OFF:  s_d.prdata = {16'h0, s_q.channel_config_register};
                    `ASS_RATE_OFF: s_d.prdata = {16'h0, s_q.rate};
                    `ASS_TIMER_OFF: s_d.prdata = {16'h0, s_q.timer};
                    default: begin
                        s_d.prdata  = in_mem ? {16'h0, ram_rdata} : 32'h0;
                        s_d.pslverr = !in_mem;
                        // read of first buffer word clears data ready
                        if (paddr == `ASS_BUF_OFF) begin
                            s_d.control_status_register[`ASS_CSR_READY] = 1'b0;
                        end
                    end
                endcase
            end
        end

        trig = sw_trig || ext_fall || (s_q.control_status_register[`ASS_CSR_TIMER] && timer_tick);
        s_d.led_on = s_q.control_status_register[`ASS_CSR_LED];

        // scan engine; a ccr or board reset write aborts a running scan
        if (s_d.restart) begin
            s_d.trig_n = 1'b1;
        end else begin
        case (s_q.st)
            ASS_ST_IDLE: begin
                s_d.trig_n = 1'b1;
                // auto scan runs on rate ticks; single waits trigger
                if ((mode == ASS_MODE_AUTO && rate_tick) ||
                    ((mode == ASS_MODE_SINGLE || mode == ASS_MODE_RANDOM) && trig)) begin
                    s_d.st  = ASS_ST_CONV;
                    s_d.idx = 11'd0;
                    s_d.trig_n = 1'b0;
                end
            end
            ASS_ST_CONV: begin
                ch = (mode == ASS_MODE_RANDOM) ? s_q.channel_config_register[5:0]
                     : base_ch | 6'(s_q.idx & 11'(chans - 7'd1));
                s_d.adc_channel = ch;
                s_d.adc_gain10  = s_q.channel_config_register[`ASS_CCR_AGAIN] ? s_q.gains[ch] : s_q.channel_config_register[`ASS_CCR_GAIN10];
                s_d.adc_start   = 1'b1;
                s_d.st          = ASS_ST_WAIT;
            end
            ASS_ST_WAIT: begin
                if (adc_done) begin
                    ram_b_we    = !(acc && s_q.rd_wait && pwrite && paddr == `ASS_GAIN_OFF);
                    ram_b_addr  = s_q.idx;
                    // coding: invert msb for two's complement
                    ram_b_wdata = adc_data ^ {s_q.control_status_register[`ASS_CSR_TWOS], 15'h0};
                    if (s_q.idx == last_idx) begin
                        s_d.trig_n  = 1'b1;
                        s_d.control_status_register[`ASS_CSR_READY] = 1'b1;
                        s_d.st  = ASS_ST_IDLE;
                        s_d.idx = 11'd0;
                    end else begin
                        s_d.idx = s_q.idx + 11'd1;
                        s_d.st  = ASS_ST_CONV;
                    end
                end
            end
            default: s_d.st = ASS_ST_IDLE;
        endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{control_status_register: `ASS_CSR_RESET, channel_config_register: `ASS_CCR_RESET, rate: `ASS_RATE_RESET,
                     timer: `ASS_TIMER_RESET, st: ASS_ST_IDLE, ext_q: 1'b1, trig_n: 1'b1,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata           = s_q.prdata;
    assign pready           = s_q.pready;
    assign pslverr          = s_q.pslverr;
    assign adc_start        = s_q.adc_start;
    assign adc_channel      = s_q.adc_channel;
    assign adc_gain10       = s_q.adc_gain10;
    assign trigger_output_n = s_q.trig_n;
    assign led_on           = s_q.led_on;
endmodule

// file: verification/ass_seq_checker_properties.sv
// concurrent checks on the ports of the scan sequencer
module ass_seq_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        external_start_n,
    input wire logic        adc_done,
    input wire logic [15:0] adc_data,
    input wire logic        adc_start,
    input wire logic [5:0]  adc_channel,
    input wire logic        adc_gain10,
    input wire logic        trigger_output_n,
    input wire logic        led_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // conversion tracking and properties
    // ------------------------------------------------------------
    logic busy_q;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // busy from a start until the converter answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            busy_q <= 1'b0;
        else
            busy_q <= adc_start | (busy_q & ~adc_done);
    end
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("pready held past one cycle");
    a_err_reads_zero:
        assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("refused access misreported");
    a_start_after_trig:
        assert property ($fell(trigger_output_n) |-> ##[0:3] adc_start) else $error("scan start without conversion");
    a_one_conv:
        assert property (adc_start |-> !busy_q) else $error("conversion started while busy");
    a_start_in_scan:
        assert property (adc_start |-> !trigger_output_n) else $error("conversion outside scan window");
    a_chan_hold:
        assert property (busy_q |-> $stable(adc_channel)) else $error("channel moved during conversion");
    a_gain_hold:
        assert property (busy_q |-> $stable(adc_gain10)) else $error("gain moved during conversion");
    a_scan_end:
        assert property ($rose(trigger_output_n) |-> !busy_q) else $error("scan ended with conversion open");
    a_led_quiet:
        assert property (!(psel && penable && pwrite) |=> $stable(led_on)) else $error("indicator changed without write");
endmodule
bind ass_adc_scan_sequencer ass_seq_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_start_n(external_start_n), .adc_done(adc_done), .adc_data(adc_data),
    .adc_start(adc_start), .adc_channel(adc_channel), .adc_gain10(adc_gain10),
    .trigger_output_n(trigger_output_n), .led_on(led_on));

// file: verification/ass_adc_model.sv
// behavioural converter answering conversion requests
module ass_adc_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        adc_start,
    input  wire logic [5:0]  adc_channel,
    input  wire logic        slow,
    output logic             adc_done,
    output logic [15:0]      adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    logic [5:0] ch_q;
    // result carries the channel; data toggles while not valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= 4'h0;
            ch_q     <= 6'h00;
            adc_done <= 1'b0;
            adc_data <= 16'h0000;
        end else begin
            adc_done <= (cnt_q == 4'h1);
            adc_data <= (cnt_q == 4'h1) ? {ch_q, 10'h3ff} : ~adc_data;
            if (adc_start) begin
                cnt_q <= slow ? 4'h9 : 4'h2;
                ch_q  <= adc_channel;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

// file: verification/tb_top.sv
// self-checking bench of the scan sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [15:0] a; logic [15:0] d; logic [15:0] x; logic e;} ass_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        external_start_n = 1'b1, slow = 1'b0, er;
    logic [15:0] paddr = 16'h0000, rd, adc_data;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, adc_done, adc_start, adc_gain10, trigger_output_n, led_on;
    logic [5:0]  adc_channel, last_ch;
    int          mismatches = 0, n_checks = 0, n_starts = 0, cycles = 0;
    ass_row_t    rows [7] = '{'{1'b0, 16'h0002, 16'h0000, 16'h8000, 1'b0},
        '{1'b0, 16'h0004, 16'h0000, 16'h5800, 1'b0}, '{1'b1, 16'h0880, 16'h1234, 16'h0000, 1'b0},
        '{1'b0, 16'h0880, 16'h0000, 16'h1234, 1'b0}, '{1'b1, 16'h0FFE, 16'hABCD, 16'h0000, 1'b0},
        '{1'b0, 16'h0FFE, 16'h0000, 16'hABCD, 1'b0}, '{1'b0, 16'h1000, 16'h0000, 16'h0000, 1'b1}};
    ass_adc_scan_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_start_n(external_start_n), .adc_done(adc_done),
        .adc_data(adc_data), .adc_start(adc_start), .adc_channel(adc_channel),
        .adc_gain10(adc_gain10), .trigger_output_n(trigger_output_n), .led_on(led_on));
    ass_adc_model u_adc (.pclk(pclk), .presetn(presetn), .adc_start(adc_start),
        .adc_channel(adc_channel), .slow(slow), .adc_done(adc_done), .adc_data(adc_data));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (adc_start === 1'b1) begin
            n_starts++;
            last_ch = adc_channel;
        end
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    function automatic logic [15:0] raw(input logic [5:0] c);
        return {c, 10'h3ff};
    endfunction
    task automatic test_done;
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
        n_checks++;
        if (s !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        r = prdata[15:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic rdchk(input string nm, input logic [15:0] a, input logic [15:0] x);
        apb(1'b0, a, 16'h0000, rd, er);
        chk(nm, rd, x);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (4) @(posedge pclk);
        while (trigger_output_n !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic scan(input logic [15:0] control_status_register, input logic [15:0] channel_config_register, input logic again);
        wr(16'h0002, control_status_register);
        wr(16'h0004, channel_config_register);
        n_starts = 0;
        wr(16'h000E, 16'h0000);
        if (again)
            wr(16'h000E, 16'hFFFF);
        wait_idle();
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
            if (!rows[i].w) chk("row data", rd, rows[i].x);
            chk("row refusal", {15'h0000, er}, {15'h0000, rows[i].e});
        end
        wait_idle();
        scan(16'h8000, 16'h5840, 1'b1);
        chk("scan count", n_starts[15:0], 16'h0040);
        rdchk("csr ready", 16'h0002, 16'h8040);
        rdchk("first word", 16'h0080, raw(6'h00));
        rdchk("last word", 16'h00FE, raw(6'h3F));
        rdchk("csr cleared", 16'h0002, 16'h8000);
        repeat (300) @(posedge pclk);
        chk("halted", n_starts[15:0], 16'h0040);
        slow <= 1'b1;
        scan(16'hC000, 16'h5840, 1'b0);
        rdchk("twos word", 16'h0080, raw(6'h00) ^ 16'h8000);
        rdchk("twos full", 16'h00FE, 16'h7FFF);
        slow <= 1'b0;
        scan(16'h8000, 16'h5885, 1'b0);
        chk("random count", n_starts[15:0], 16'h0001);
        chk("random chan", {10'h000, last_ch}, 16'h0005);
        rdchk("random word", 16'h0080, raw(6'h05));
        wr(16'h0002, 16'h9000);
        wr(16'h0004, 16'h5887);
        n_starts = 0;
        // start held low beyond 250 ns
        external_start_n <= 1'b0;
        repeat (32) @(posedge pclk);
        external_start_n <= 1'b1;
        wait_idle();
        chk("ext count", n_starts[15:0], 16'h0001);
        chk("ext chan", {10'h000, last_ch}, 16'h0007);
        rdchk("ext word", 16'h0080, raw(6'h07));
        wr(16'h0002, 16'hA000);
        wr(16'h0004, 16'h5886);
        repeat (60) @(posedge pclk);
        chk("timer chan", {10'h000, last_ch}, 16'h0006);
        wr(16'h0002, 16'h8100);
        wr(16'h0004, 16'h5A85);
        repeat (5) wr(16'h0010, 16'h0000);
        wr(16'h0010, 16'h0001);
        wr(16'h000E, 16'h0000);
        wait_idle();
        chk("auto gain", {15'h0000, adc_gain10}, 16'h0001);
        chk("led on", {15'h0000, led_on}, 16'h0001);
        wr(16'h000C, 16'h1234);
        rdchk("soft reset ccr", 16'h0004, 16'h5800);
        test_done();
    end
endmodule
